// ### verilog/srgt_pkg.sv
package srgt_pkg;
   // Widths
   localparam int CNT_W        = 16;
   localparam int LVL_W        = 6;
   localparam int STRAP_W      = 3;
   localparam int STEP_W       = 2;

   // Clock
   localparam int CLK_NS       = 40;

   // Timer anticipation, 14 ns rounded down to whole cycles, never below one cycle, so one 40 ns cycle
   localparam int ANT_NS       = 14;
   localparam int ANT_CYC      = (ANT_NS / CLK_NS) < 1 ? 1 : (ANT_NS / CLK_NS);
   localparam int TIMER_STEP   = 1;
   localparam int STEP_EVERY   = 4;

   // Sleep thresholds: min-on plus a fixed margin, exit adds one fifth of min-on
   localparam int SLEEP_ADD_NS = 300;
   localparam int SLEEP_ADD_CYC = (SLEEP_ADD_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLEEP_OUT_DIV = 5;

   // Switching-stop interval
   localparam int STOP_NS      = 120000;
   localparam int STOP_CYC     = STOP_NS / CLK_NS;

   // Target residual diode time
   localparam int DIODE_TGT_NS = 200;
   localparam int DIODE_TGT_CYC = (DIODE_TGT_NS + CLK_NS - 1) / CLK_NS;

   // Maximum gate pulse
   localparam int TON_MAX_NS   = 20000;
   localparam int TON_MAX_CYC  = TON_MAX_NS / CLK_NS;

   // Minimum-off blanking, three build variants
   localparam int TOFF_NS_V0   = 1500;
   localparam int TOFF_NS_V1   = 2500;
   localparam int TOFF_NS_V2   = 3500;

   // Strap phase length in switching cycles
   localparam int STRAP_CYCLES = 5;

   typedef enum logic [2:0] {
      SRGT_ST_OFF   = 3'h0,
      SRGT_ST_STRAP = 3'h1,
      SRGT_ST_SLEEP = 3'h3,
      SRGT_ST_RUN   = 3'h2,
      SRGT_ST_BURST = 3'h6
   } srgt_state_t;
endpackage

// ### verilog/srgt_gate_timing.sv
`timescale 1ns/1ps
// Contract
// R1: Drain falls below threshold, gate on fast
// R2: Ignore turn-off during programmed minimum-on
// R3: Stop gating when conduction undercuts minimum-on
// R4: First of zero-cross or timer ends pulse
// R5: Adapt turn-off threshold toward target diode time
// R6: Diode time: gate fall to drain rise
// R7: Timer drops gate one anticipation before rise
// R8: Strap capacitor selects CCM, else QR/DCM
// R9: CCM timer uses averaged period estimate; code takes a shorter period at once and grows one step per four rises
// R10: Anticipation max 14 ns, step every 4; code anticipates one 40 ns cycle
// R11: Primary limits period growth per cycle
// R12: QR timer uses previous demagnetization time
// R13: Minimum-off until drain stays high long enough
// R14: Minimum-off is one of three variants
// R15: High-drain comparator ends minimum-off early
// R16: Strap phase lasts five switching cycles
// R17: Latched mode held while supply stays up
// R18: Strap then sleep, run on long demag
// R19: Run entry starts threshold at floor
// R20: Sleep in/out thresholds, one cycle each
// R21: Switching stop enters low-power sleep
// R22: Maximum on-time ends every pulse
// R23: Operate between supply on and off thresholds
// R24: Synchronise comparators, time by clock counts
// R25: Supply loss drops gate, resets state
module srgt_gate_timing #(
   parameter int TOFF_VARIANT = 0
) (
   // Clock and reset
   input  wire logic                          i_clk,
   input  wire logic                          i_srst,
   // Comparators, asynchronous
   input  wire logic                          i_drain_below,
   input  wire logic                          i_zero_cross_trip,
   input  wire logic                          i_high_drain_trip,
   input  wire logic                          i_strap_cap_seen,
   input  wire logic                          i_supply_above_on,
   input  wire logic                          i_supply_above_off,
   // Minimum-on from on-time resistor, in clock cycles
   input  wire logic [srgt_pkg::CNT_W-1:0]    i_min_on_cycles,
   // Outputs
   output logic                               o_gate,
   output logic                               o_ccm_mode,
   output logic [2:0]                         o_state,
   output logic [srgt_pkg::LVL_W-1:0]         o_zc_level
);
   localparam int TOFF_NS  = TOFF_VARIANT == 0 ? srgt_pkg::TOFF_NS_V0 :
                             TOFF_VARIANT == 1 ? srgt_pkg::TOFF_NS_V1 : srgt_pkg::TOFF_NS_V2;
   localparam int TOFF_CYC = (TOFF_NS + srgt_pkg::CLK_NS - 1) / srgt_pkg::CLK_NS; // R14
   localparam int CW       = srgt_pkg::CNT_W;

   function automatic logic [CW-1:0] inc_sat(input logic [CW-1:0] v);
      inc_sat = (&v) ? v : v + CW'(1);
   endfunction

   logic [5:0]                 sync1_reg;
   logic [5:0]                 sync2_reg;
   logic                       below_prev_reg;
   srgt_pkg::srgt_state_t      state_reg;
   logic [CW-1:0]              cond_cnt_reg;
   logic [CW-1:0]              stop_cnt_reg;
   logic [srgt_pkg::STRAP_W-1:0] strap_cnt_reg;
   logic                       strap_seen_reg;
   logic                       ccm_reg;
   logic                       gate_reg;
   logic [CW-1:0]              on_cnt_reg;
   logic                       blank_reg;
   logic [CW-1:0]              off_cnt_reg;
   logic                       diode_run_reg;
   logic [CW-1:0]              diode_cnt_reg;
   logic [srgt_pkg::LVL_W-1:0] lvl_reg;
   logic [CW-1:0]              demag_reg;
   logic [CW-1:0]              est_reg;
   logic [srgt_pkg::STEP_W-1:0] step_cnt_reg;

   logic          below;
   logic          zc_trip;
   logic          hd_trip;
   logic          strap_cap;
   logic          sup_on;
   logic          sup_ok;
   logic          fall;
   logic          rise;
   logic          stop_hit;
   logic [CW-1:0] pred;
   logic          timer_hit;
   logic          turn_on;
   logic          turn_off;
   logic [CW-1:0] sleep_in;
   logic [CW-1:0] sleep_out;

   // Two flops before any logic; metastability kept off the comparators
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sync1_reg      <= '0;
         sync2_reg      <= '0;
         below_prev_reg <= 1'b0;
      end else begin
         sync1_reg      <= {i_supply_above_off, i_supply_above_on, i_strap_cap_seen,
                            i_high_drain_trip, i_zero_cross_trip, i_drain_below}; // R24
         sync2_reg      <= sync1_reg;
         below_prev_reg <= sync2_reg[0];
      end
   end

   assign below     = sync2_reg[0];
   assign zc_trip   = sync2_reg[1];
   assign hd_trip   = sync2_reg[2];
   assign strap_cap = sync2_reg[3];
   assign sup_on    = sync2_reg[4];
   assign sup_ok    = sync2_reg[5];
   assign fall      = below & ~below_prev_reg;
   assign rise      = ~below & below_prev_reg;
   assign stop_hit  = stop_cnt_reg >= CW'(srgt_pkg::STOP_CYC);
   assign sleep_in  = i_min_on_cycles + CW'(srgt_pkg::SLEEP_ADD_CYC); // R20
   assign sleep_out = i_min_on_cycles + i_min_on_cycles / CW'(srgt_pkg::SLEEP_OUT_DIV)
                      + CW'(srgt_pkg::SLEEP_ADD_CYC); // R20

   // Predicted rise instant, counted from the drain fall
   assign pred      = ccm_reg ? est_reg : demag_reg; // R9 R12
   assign timer_hit = (pred != '0) && (on_cnt_reg + CW'(srgt_pkg::ANT_CYC) >= pred); // R7 R10
   assign turn_on   = (state_reg == srgt_pkg::SRGT_ST_RUN) && sup_ok && !gate_reg && fall && !blank_reg; // R1
   assign turn_off  = gate_reg && (on_cnt_reg >= CW'(srgt_pkg::TON_MAX_CYC) || // R22
                      (on_cnt_reg >= i_min_on_cycles && (zc_trip || timer_hit || !below))); // R2 R3 R4

   // Conduction and switching-stop timers
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cond_cnt_reg <= '0;
         stop_cnt_reg <= '0;
      end else begin
         cond_cnt_reg <= fall ? CW'(1) : (below ? inc_sat(cond_cnt_reg) : cond_cnt_reg); // R24
         stop_cnt_reg <= below ? '0 : inc_sat(stop_cnt_reg);
      end
   end

   // Operating state
   always_ff @(posedge i_clk) begin
      if (i_srst || !sup_ok) begin
         state_reg <= srgt_pkg::SRGT_ST_OFF; // R23 R25
      end else begin
         case (state_reg)
            srgt_pkg::SRGT_ST_OFF: begin
               if (sup_on) state_reg <= srgt_pkg::SRGT_ST_STRAP; // R23
            end
            srgt_pkg::SRGT_ST_STRAP: begin
               if (fall && strap_cnt_reg == srgt_pkg::STRAP_W'(srgt_pkg::STRAP_CYCLES - 1)) begin
                  state_reg <= srgt_pkg::SRGT_ST_SLEEP; // R16 R18
               end
            end
            srgt_pkg::SRGT_ST_SLEEP: begin
               if (stop_hit) state_reg <= srgt_pkg::SRGT_ST_BURST;
               else if (rise && cond_cnt_reg > sleep_out) state_reg <= srgt_pkg::SRGT_ST_RUN; // R18 R20
            end
            srgt_pkg::SRGT_ST_RUN: begin
               if (stop_hit) state_reg <= srgt_pkg::SRGT_ST_BURST; // R21
               else if (rise && cond_cnt_reg < sleep_in) state_reg <= srgt_pkg::SRGT_ST_SLEEP; // R3 R20
            end
            srgt_pkg::SRGT_ST_BURST: begin
               // First edge after a stop is never driven
               if (fall) state_reg <= srgt_pkg::SRGT_ST_SLEEP;
            end
            default: state_reg <= srgt_pkg::SRGT_ST_OFF;
         endcase
      end
   end

   // Strap detection and mode latch
   always_ff @(posedge i_clk) begin
      if (i_srst || state_reg == srgt_pkg::SRGT_ST_OFF) begin
         strap_cnt_reg  <= '0;
         strap_seen_reg <= 1'b0;
         ccm_reg        <= 1'b0;
      end else if (state_reg == srgt_pkg::SRGT_ST_STRAP) begin
         strap_seen_reg <= strap_seen_reg | strap_cap; // R8
         if (fall) begin
            strap_cnt_reg <= strap_cnt_reg + srgt_pkg::STRAP_W'(1); // R16
            ccm_reg       <= strap_seen_reg | strap_cap; // R8 R17
         end
      end
   end

   // Gate drive
   always_ff @(posedge i_clk) begin
      if (i_srst || !sup_ok || state_reg != srgt_pkg::SRGT_ST_RUN) begin
         gate_reg   <= 1'b0; // R25
         on_cnt_reg <= '0;
      end else if (turn_on) begin
         gate_reg   <= 1'b1; // R1
         on_cnt_reg <= CW'(1);
      end else if (turn_off) begin
         gate_reg   <= 1'b0; // R4
      end else if (gate_reg) begin
         on_cnt_reg <= inc_sat(on_cnt_reg);
      end
   end

   // Minimum-off blanking; any low dip of the drain restarts the count
   always_ff @(posedge i_clk) begin
      if (i_srst || !sup_ok) begin
         blank_reg   <= 1'b0;
         off_cnt_reg <= '0;
      end else if (turn_off) begin
         blank_reg   <= 1'b1; // R13
         off_cnt_reg <= '0;
      end else if (blank_reg) begin
         off_cnt_reg <= below ? '0 : inc_sat(off_cnt_reg); // R13
         if (hd_trip || (!below && off_cnt_reg >= CW'(TOFF_CYC - 1))) blank_reg <= 1'b0; // R13 R15
      end
   end

   // Residual diode time and threshold adaption
   always_ff @(posedge i_clk) begin
      if (i_srst || state_reg != srgt_pkg::SRGT_ST_RUN) begin
         diode_run_reg <= 1'b0;
         diode_cnt_reg <= '0;
         lvl_reg       <= '0; // R19
      end else if (turn_off) begin
         diode_run_reg <= 1'b1; // R6
         diode_cnt_reg <= '0;
      end else if (diode_run_reg) begin
         if (!below) begin
            diode_run_reg <= 1'b0; // R6
            // Long diode tail means turn-off came early: lower the threshold level
            if (diode_cnt_reg > CW'(srgt_pkg::DIODE_TGT_CYC) && lvl_reg != '0) begin
               lvl_reg <= lvl_reg - srgt_pkg::LVL_W'(1); // R5
            end else if (diode_cnt_reg < CW'(srgt_pkg::DIODE_TGT_CYC) && !(&lvl_reg)) begin
               lvl_reg <= lvl_reg + srgt_pkg::LVL_W'(1); // R5
            end
         end else begin
            diode_cnt_reg <= inc_sat(diode_cnt_reg);
         end
      end
   end

   // Timer predictors; estimate grows slowly, shrinks at once
   always_ff @(posedge i_clk) begin
      if (i_srst || state_reg == srgt_pkg::SRGT_ST_OFF) begin
         demag_reg    <= '0;
         est_reg      <= '0;
         step_cnt_reg <= '0;
      end else if (rise) begin
         demag_reg    <= cond_cnt_reg; // R12
         step_cnt_reg <= step_cnt_reg + srgt_pkg::STEP_W'(1);
         if (cond_cnt_reg < est_reg || est_reg == '0) begin
            est_reg <= cond_cnt_reg; // R9
         end else if (cond_cnt_reg > est_reg &&
                      step_cnt_reg == srgt_pkg::STEP_W'(srgt_pkg::STEP_EVERY - 1)) begin
            est_reg <= est_reg + CW'(srgt_pkg::TIMER_STEP); // R10
         end
      end
   end

   assign o_gate     = gate_reg;
   assign o_ccm_mode = ccm_reg;
   assign o_state    = state_reg;
   assign o_zc_level = lvl_reg;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   a_supply_drop_off: assert property (!sup_ok |=> !gate_reg && state_reg == srgt_pkg::SRGT_ST_OFF) // R25
      else $error("gate or state not cleared on supply loss");
   a_gate_only_run: assert property (state_reg != srgt_pkg::SRGT_ST_RUN |=> !gate_reg) // R23
      else $error("gate driven outside run state");
   a_turn_on_fast: assert property (turn_on |=> gate_reg && on_cnt_reg == CW'(1)) // R1
      else $error("gate did not rise after drain fall");
   a_min_on_hold: assert property (gate_reg && on_cnt_reg < i_min_on_cycles && sup_ok &&
      on_cnt_reg < CW'(srgt_pkg::TON_MAX_CYC) && state_reg == srgt_pkg::SRGT_ST_RUN |=> gate_reg) // R2
      else $error("gate dropped inside minimum-on");
   a_max_on_limit: assert property (gate_reg && on_cnt_reg >= CW'(srgt_pkg::TON_MAX_CYC) |=> !gate_reg) // R22
      else $error("gate exceeded maximum on-time");
   a_blank_follows_off: assert property ($fell(gate_reg) && state_reg == srgt_pkg::SRGT_ST_RUN |-> blank_reg) // R13
      else $error("no blanking after gate fall");
   a_no_on_blanked: assert property (blank_reg |=> !$rose(gate_reg)) // R13
      else $error("gate rose during minimum-off");
   a_high_drain_end: assert property (blank_reg && hd_trip && !turn_off && sup_ok |=> !blank_reg) // R15
      else $error("high drain did not end blanking");
   a_mode_held: assert property (state_reg != srgt_pkg::SRGT_ST_OFF && state_reg != srgt_pkg::SRGT_ST_STRAP &&
      sup_ok |=> $stable(ccm_reg)) // R17
      else $error("timer mode changed while powered");
   a_run_floor: assert property (state_reg != srgt_pkg::SRGT_ST_RUN ##1 state_reg == srgt_pkg::SRGT_ST_RUN
      |-> lvl_reg == '0) // R19
      else $error("threshold not at floor on run entry");
   a_stop_burst: assert property ((state_reg == srgt_pkg::SRGT_ST_RUN || state_reg == srgt_pkg::SRGT_ST_SLEEP) &&
      stop_hit && sup_ok
      |=> state_reg == srgt_pkg::SRGT_ST_BURST) // R21
      else $error("switching stop did not enter low power");
endmodule // srgt_gate_timing

// ### test/srgt_drain_model.sv
`timescale 1ns/1ps
module srgt_drain_model (
   // Clock and gate sense
   input  wire logic i_clk,
   input  wire logic i_gate,
   // Comparators toward the block
   output logic      o_drain_below,
   output logic      o_zero_cross_trip,
   output logic      o_high_drain_trip
);
   initial begin
      o_drain_below     = 1'b0;
      o_zero_cross_trip = 1'b0;
      o_high_drain_trip = 1'b0;
   end

   // One conduction then a gap; no frequency modulation at all
   task automatic conduct(input int len, input int zc_at, input int gap, input bit hd, output int gate_cyc);
      gate_cyc = 0;
      o_drain_below <= 1'b1;
      for (int i = 0; i < len; i++) begin
         @(posedge i_clk);
         if (i_gate === 1'b1) gate_cyc++;
         if (i + 1 == zc_at) o_zero_cross_trip <= 1'b1;
      end
      o_drain_below     <= 1'b0;
      o_zero_cross_trip <= 1'b0;
      o_high_drain_trip <= hd;
      for (int i = 0; i < gap; i++) begin
         @(posedge i_clk);
         if (i_gate === 1'b1) gate_cyc++;
         if (i == 2) o_high_drain_trip <= 1'b0;
      end
   endtask
endmodule // srgt_drain_model

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
   logic                         i_clk;
   logic                         i_srst;
   logic                         i_strap_cap_seen;
   logic                         i_supply_above_on;
   logic                         i_supply_above_off;
   logic [srgt_pkg::CNT_W-1:0]   i_min_on_cycles;
   logic                         drain_below;
   logic                         zc_trip;
   logic                         hd_trip;
   logic                         o_gate;
   logic                         o_ccm_mode;
   logic [2:0]                   o_state;
   logic [srgt_pkg::LVL_W-1:0]   o_zc_level;
   int                           mismatches;
   int                           comparisons;
   int                           cyc;
   int                           g;

   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   srgt_gate_timing #(.TOFF_VARIANT(0)) dut_u (
      .i_clk(i_clk), .i_srst(i_srst), .i_drain_below(drain_below), .i_zero_cross_trip(zc_trip),
      .i_high_drain_trip(hd_trip), .i_strap_cap_seen(i_strap_cap_seen), .i_supply_above_on(i_supply_above_on),
      .i_supply_above_off(i_supply_above_off), .i_min_on_cycles(i_min_on_cycles), .o_gate(o_gate),
      .o_ccm_mode(o_ccm_mode), .o_state(o_state), .o_zc_level(o_zc_level));

   srgt_drain_model model_u (
      .i_clk(i_clk), .i_gate(o_gate), .o_drain_below(drain_below),
      .o_zero_cross_trip(zc_trip), .o_high_drain_trip(hd_trip));

   task automatic ticks(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   task automatic chk_eq(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      comparisons++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic t_startup(input logic strap);
      i_strap_cap_seen   <= strap;
      i_supply_above_on  <= 1'b1;
      i_supply_above_off <= 1'b1;
      ticks(6);
      chk_eq("state strap", 16'h0001, 16'(o_state));
      for (int k = 0; k < 4; k++) model_u.conduct(10, 0, 50, 1'b0, g);
      chk_eq("state after four", 16'h0001, 16'(o_state));
      model_u.conduct(10, 0, 50, 1'b0, g);
      chk_eq("state after five", 16'h0003, 16'(o_state));
      chk_eq("mode latched", 16'(strap), 16'(o_ccm_mode));
      i_strap_cap_seen <= ~strap;
      model_u.conduct(10, 0, 50, 1'b0, g);
      chk_eq("mode held", 16'(strap), 16'(o_ccm_mode));
      chk_rng("sleep gate", 0, 0, g);
      model_u.conduct(100, 0, 60, 1'b0, g);
      chk_eq("state run", 16'h0002, 16'(o_state));
      chk_eq("level floor", 16'h0000, 16'(o_zc_level));
      $display("test startup done");
   endtask

   // Estimate grows one step per four rises, so the timer ends the pulse at min-on
   task automatic t_ccm();
      model_u.conduct(34, 0, 60, 1'b0, g);
      model_u.conduct(100, 80, 60, 1'b0, g);
      model_u.conduct(100, 80, 60, 1'b0, g);
      chk_rng("ccm width", 19, 21, g);
      $display("test ccm done");
   endtask

   task automatic t_blank();
      model_u.conduct(100, 50, 10, 1'b0, g);
      model_u.conduct(100, 50, 60, 1'b0, g);
      chk_rng("blanked gate", 0, 0, g);
      model_u.conduct(100, 50, 10, 1'b1, g);
      model_u.conduct(100, 50, 60, 1'b0, g);
      chk_rng("early end gate", 20, 60, g);
      $display("test blank done");
   endtask

   task automatic t_sleep_burst();
      model_u.conduct(22, 0, 60, 1'b0, g);
      chk_eq("short to sleep", 16'h0003, 16'(o_state));
      model_u.conduct(22, 0, 3100, 1'b0, g);
      chk_eq("burst state", 16'h0006, 16'(o_state));
      model_u.conduct(100, 0, 60, 1'b0, g);
      chk_rng("restart skipped", 0, 0, g);
      $display("test sleep burst done");
   endtask

   task automatic t_qr();
      model_u.conduct(150, 0, 60, 1'b0, g);
      chk_rng("timer width", 90, 104, g);
      model_u.conduct(150, 50, 60, 1'b0, g);
      chk_rng("zero cross width", 44, 54, g);
      model_u.conduct(150, 3, 60, 1'b0, g);
      chk_rng("min on width", 16, 24, g);
      model_u.conduct(150, 148, 60, 1'b0, g);
      chk_eq("level step", 16'h0001, 16'(o_zc_level));
      model_u.conduct(700, 0, 60, 1'b0, g);
      model_u.conduct(700, 0, 60, 1'b0, g);
      chk_rng("max on width", 495, 505, g);
      chk_eq("level back down", 16'h0000, 16'(o_zc_level));
      $display("test qr done");
   endtask

   task automatic t_supply(input bit on_chk);
      fork
         model_u.conduct(200, 0, 60, 1'b0, g);
         begin
            ticks(40);
            if (on_chk) chk_eq("gate on", 16'h0001, 16'(o_gate));
            i_supply_above_off <= 1'b0;
            ticks(5);
            chk_eq("gate on loss", 16'h0000, 16'(o_gate));
            chk_eq("state on loss", 16'h0000, 16'(o_state));
         end
      join
      $display("test supply done");
   endtask

   // Whole run needs under 10000 cycles
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         $display("[FAIL] timeout expected finish seen hang");
         end_of_test();
      end
   end

   initial begin
      mismatches         = 0;
      comparisons        = 0;
      cyc                = 0;
      i_srst             = 1'b1;
      i_strap_cap_seen   = 1'b0;
      i_supply_above_on  = 1'b0;
      i_supply_above_off = 1'b0;
      i_min_on_cycles    = 16'h0014;
      ticks(4);
      i_srst <= 1'b0;
      ticks(1);
      chk_eq("reset gate", 16'h0000, 16'(o_gate));
      chk_eq("reset state", 16'h0000, 16'(o_state));
      t_startup(1'b1);
      t_ccm();
      t_blank();
      t_sleep_burst();
      t_supply(1'b0);
      t_startup(1'b0);
      t_qr();
      t_supply(1'b1);
      end_of_test();
   end
endmodule // tb
